/* File: bench/dcp_param_regs_assertions.sv */
// Purpose: Port checks for the component parameter register bank.
// Assumes: Expected words are built from the bank parameters in the bind.
// Notes: Reset is synchronous, so all checks rest while it is held.
`default_nettype none

module dcp_param_regs_assertions
    import dcp_pkg::*;
#(
    parameter logic [31:0] W0 = 32'h0,
    parameter logic [31:0] WK = 32'h0,
    parameter logic [31:0] WL = 32'h888
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [DCP_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [DCP_DATA_W-1:0] reg_rdata_o,
    input wire logic reg_err_o,
    input wire logic [DCP_COUNT_W-1:0] chan0_block_limit_o,
    input wire logic [DCP_COUNT_W-1:0] chan1_block_limit_o,
    input wire logic [DCP_COUNT_W-1:0] chan2_block_limit_o,
    input wire logic params_legal_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Codes above ten name no limit, so the count collapses to zero.
    function automatic logic [11:0] cnt(input logic [3:0] c);
        return (c > 4'ha) ? 12'h0 : 12'((13'h1 << (c + 4'h2)) - 13'h1);
    endfunction : cnt
    localparam logic OK = WK[3:0] <= 4'h8 && WK[7:4] <= 4'h8 && WK[11:8] <= 4'h8
        && W0[5:3] <= 3'h6 && W0[2:0] <= 3'h6 && WL[3:0] <= 4'ha
        && WL[7:4] <= 4'ha && WL[11:8] <= 4'ha;
    logic hit;
    assign hit = reg_addr_i inside {DCP_OFS_CHAN0, DCP_OFS_KIND, DCP_OFS_LIMIT};
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);
    sequence s_rd(logic [11:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    property p_chan0;
        s_rd(DCP_OFS_CHAN0) |=> reg_rdata_o == W0;
    endproperty
    a_chan0: assert property (p_chan0)
        else $error("chan0 word wrong");
    property p_kind;
        s_rd(DCP_OFS_KIND) |=> reg_rdata_o == WK;
    endproperty
    a_kind: assert property (p_kind)
        else $error("kind word wrong");
    property p_limit;
        s_rd(DCP_OFS_LIMIT) |=> reg_rdata_o == WL;
    endproperty
    a_limit: assert property (p_limit)
        else $error("limit word wrong");
    property p_idle;
        !reg_rd_i |=> reg_rdata_o == 32'h0;
    endproperty
    a_idle: assert property (p_idle)
        else $error("data without read");
    property p_wr;
        reg_wr_i |=> reg_err_o;
    endproperty
    a_wr: assert property (p_wr)
        else $error("write not refused");
    property p_miss;
        reg_rd_i && !hit |=> reg_err_o && reg_rdata_o == 32'h0;
    endproperty
    a_miss: assert property (p_miss)
        else $error("unmapped read wrong");
    property p_quiet;
        !reg_wr_i && !(reg_rd_i && !hit) |=> !reg_err_o;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("spurious error");
    property p_count;
        !$past(srst_i) |-> chan0_block_limit_o == cnt(WL[3:0])
            && chan1_block_limit_o == cnt(WL[7:4]) && chan2_block_limit_o == cnt(WL[11:8]);
    endproperty
    a_count: assert property (p_count)
        else $error("block limit wrong");
    property p_legal;
        !$past(srst_i) |-> params_legal_o == OK;
    endproperty
    a_legal: assert property (p_legal)
        else $error("legal flag wrong");
endmodule : dcp_param_regs_assertions

bind dcp_param_regs dcp_param_regs_assertions #(
    .W0({21'h0, CH0_LOCK, CH0_GATHER, CH0_SCATTER, 2'h0, CH0_SRC_WIDTH, CH0_DST_WIDTH}),
    .WK({20'h0, CH2_KIND, CH1_KIND, CH0_KIND}),
    .WL({20'h0, CH2_LIMIT, CH1_LIMIT, CH0_LIMIT})
) u_chk (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_err_o(reg_err_o),
    .chan0_block_limit_o(chan0_block_limit_o),
    .chan1_block_limit_o(chan1_block_limit_o),
    .chan2_block_limit_o(chan2_block_limit_o),
    .params_legal_o(params_legal_o)
);

`default_nettype wire

/* File: bench/dcp_param_regs_tb.sv */
// Purpose: Directed bench for the component parameter register bank.
// Assumes: Bank built with a few codes moved off their defaults so misplaced fields show.
// Notes: Only five build settings are overridden; the rest read back their defaults.
`default_nettype none

module dcp_param_regs_tb
    import dcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] ofs [3] = '{DCP_OFS_CHAN0, DCP_OFS_KIND, DCP_OFS_LIMIT};
    logic [31:0] exw [3] = '{{21'h0, 1'b1, 1'b0, 1'b0, 2'h0, 3'h5, 3'h2},
        {20'h0, 4'h8, DCP_KIND_DEF, DCP_KIND_DEF},
        {20'h0, DCP_LIMIT_DEF, 4'ha, DCP_LIMIT_DEF}};
    logic [11:0] bad [3] = '{12'h3f4, 12'h000, 12'h3ed};
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [11:0] reg_addr_i = 12'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic reg_err_o;
    logic [11:0] lim0;
    logic [11:0] lim1;
    logic [11:0] lim2;
    logic legal;
    logic [31:0] rd_data;
    logic rd_err;
    int mismatches = 0;
    int comparisons = 0;

    dcp_param_regs #(
        .CH0_LOCK(1'b1),
        .CH0_SRC_WIDTH(3'h5),
        .CH0_DST_WIDTH(3'h2),
        .CH2_KIND(4'h8),
        .CH1_LIMIT(4'ha)
    ) dut (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .reg_err_o(reg_err_o),
        .chan0_block_limit_o(lim0),
        .chan1_block_limit_o(lim1),
        .chan2_block_limit_o(lim2),
        .params_legal_o(legal)
    );

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    // Answer is taken one cycle after the strobe edge, the only cycle it stands.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_wr_i <= wr;
        reg_rd_i <= !wr;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1;
        rd_data = reg_rdata_o;
        rd_err = reg_err_o;
    endtask : bus

    task automatic read_all;
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b0, ofs[i], 32'h0);
            chk(exw[i], rd_data);
            chk(32'h0, 32'(rd_err));
        end
    endtask : read_all

    task automatic t_fields;
        read_all();
        @(posedge sys_clk_i);
        #1;
        chk(32'h0, reg_rdata_o);
        chk(32'h3ff, 32'(lim0));
        chk(32'hfff, 32'(lim1));
        chk(32'h3ff, 32'(lim2));
        chk(32'h1, 32'(legal));
        $display("test fields done");
    endtask : t_fields

    task automatic t_write;
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, ofs[i], 32'hffffffff);
            chk(32'h1, 32'(rd_err));
        end
        read_all();
        $display("test write done");
    endtask : t_write

    task automatic t_unmapped;
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b0, bad[i], 32'h0);
            chk(32'h0, rd_data);
            chk(32'h1, 32'(rd_err));
        end
        $display("test unmapped done");
    endtask : t_unmapped

    // A read issued beside reset must be swallowed, so the cleared outputs mean something.
    task automatic t_reset;
        @(posedge sys_clk_i);
        srst_i <= 1'b1;
        reg_rd_i <= 1'b1;
        reg_addr_i <= DCP_OFS_CHAN0;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(32'h0, reg_rdata_o);
        chk(32'h0, 32'(reg_err_o));
        chk(32'h0, 32'(lim1));
        chk(32'h0, 32'(legal));
        @(posedge sys_clk_i);
        srst_i <= 1'b0;
        read_all();
        chk(32'hfff, 32'(lim1));
        chk(32'h1, 32'(legal));
        $display("test reset done");
    endtask : t_reset

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    initial
    begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // The tests need about 55 cycles; a generous margin keeps the limit safe.
    initial
    begin
        repeat (2000) @(posedge sys_clk_i);
        mismatches++;
        give_verdict();
    end

    initial
    begin
        repeat (20) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        t_fields();
        t_write();
        t_unmapped();
        t_reset();
        give_verdict();
    end
endmodule : dcp_param_regs_tb

`default_nettype wire

/* File: src/dcp_code_check.sv */
// Purpose: Flags a build code that lies outside its legal range.
// Assumes: Codes are unsigned and zero is always legal.
// Notes: Purely combinational; the caller registers the result.
`default_nettype none

module dcp_code_check #(
    parameter int W = 4,
    parameter logic [W-1:0] MAX = '1
) (
    input wire logic [W-1:0] code_i,
    output logic legal_o
);

    // A reserved code must never be mistaken for a usable setting.
    assign legal_o = (code_i <= MAX);

endmodule : dcp_code_check

`default_nettype wire

/* File: src/dcp_limit_decode.sv */
// Purpose: Turns a block limit code into a transfer count.
// Assumes: The code may be out of range; it is checked against its maximum here.
// Notes: Out of range codes yield zero so no bogus limit escapes.
`default_nettype none

module dcp_limit_decode
    import dcp_pkg::*;
(
    input wire logic [DCP_FIELD_W-1:0] code_i,
    output logic [DCP_COUNT_W-1:0] count_o
);

    logic [DCP_COUNT_W:0] pow_w;

    assign pow_w = (DCP_COUNT_W+1)'(1) << (code_i + DCP_FIELD_W'(DCP_LIMIT_SHIFT));
    // Limit is two to the power code plus two, minus one.
    assign count_o = (code_i <= DCP_LIMIT_MAX) ?
        DCP_COUNT_W'(pow_w - (DCP_COUNT_W+1)'(1)) : '0;

endmodule : dcp_limit_decode

`default_nettype wire

/* File: src/dcp_param_regs.sv */
// Purpose: Read-only component parameter registers of the DMA controller.
// Assumes: Plain register port, read data valid the cycle after the strobe.
// Notes: Fields are frozen at reset from module parameters.
`default_nettype none

module dcp_param_regs
    import dcp_pkg::*;
#(
    parameter logic CH0_LOCK = DCP_FLAG_DEF,
    parameter logic CH0_GATHER = DCP_FLAG_DEF,
    parameter logic CH0_SCATTER = DCP_FLAG_DEF,
    parameter logic [2:0] CH0_SRC_WIDTH = DCP_WIDTH_DEF,
    parameter logic [2:0] CH0_DST_WIDTH = DCP_WIDTH_DEF,
    parameter logic [3:0] CH0_KIND = DCP_KIND_DEF,
    parameter logic [3:0] CH1_KIND = DCP_KIND_DEF,
    parameter logic [3:0] CH2_KIND = DCP_KIND_DEF,
    parameter logic [3:0] CH0_LIMIT = DCP_LIMIT_DEF,
    parameter logic [3:0] CH1_LIMIT = DCP_LIMIT_DEF,
    parameter logic [3:0] CH2_LIMIT = DCP_LIMIT_DEF
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [DCP_ADDR_W-1:0] reg_addr_i,
    input wire logic [DCP_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DCP_DATA_W-1:0] reg_rdata_o,
    output logic reg_err_o,
    output logic [DCP_COUNT_W-1:0] chan0_block_limit_o,
    output logic [DCP_COUNT_W-1:0] chan1_block_limit_o,
    output logic [DCP_COUNT_W-1:0] chan2_block_limit_o,
    output logic params_legal_o
);

    localparam int NF = DCP_NUM_CH;
    localparam logic [NF*DCP_FIELD_W-1:0] KIND_P = {CH2_KIND, CH1_KIND, CH0_KIND};
    localparam logic [NF*DCP_FIELD_W-1:0] LIMIT_P = {CH2_LIMIT, CH1_LIMIT, CH0_LIMIT};

    typedef enum logic [1:0] {
        dcp_sel_none = 2'h0,
        dcp_sel_chan0 = 2'h1,
        dcp_sel_kind = 2'h3,
        dcp_sel_limit = 2'h2
    } dcp_sel_e;

    // Word decode, shared by the read and the write path.
    function automatic dcp_sel_e dcp_decode(input logic [DCP_ADDR_W-1:0] addr);
        dcp_sel_e sel;
        sel = dcp_sel_none;
        unique case (addr)
            DCP_OFS_CHAN0:
            begin
                sel = dcp_sel_chan0;
            end
            DCP_OFS_KIND:
            begin
                sel = dcp_sel_kind;
            end
            DCP_OFS_LIMIT:
            begin
                sel = dcp_sel_limit;
            end
            default:
            begin
                sel = dcp_sel_none;
            end
        endcase
        return sel;
    endfunction : dcp_decode

    logic lock_q;
    logic gather_q;
    logic scatter_q;
    logic [DCP_WCODE_W-1:0] src_width_q;
    logic [DCP_WCODE_W-1:0] dst_width_q;
    logic [DCP_FIELD_W-1:0] kind_q [NF];
    logic [DCP_FIELD_W-1:0] limit_q [NF];
    logic [DCP_COUNT_W-1:0] count_q [NF];
    logic [DCP_COUNT_W-1:0] count_w [NF];
    logic [NF-1:0] kind_ok_w;
    logic [NF-1:0] limit_ok_w;
    logic src_ok_w;
    logic dst_ok_w;
    logic legal_q;
    logic [DCP_DATA_W-1:0] rdata_d;
    logic [DCP_DATA_W-1:0] rdata_q;
    logic err_d;
    logic err_q;
    logic [DCP_DATA_W-1:0] chan0_word_w;
    logic [DCP_DATA_W-1:0] kind_word_w;
    logic [DCP_DATA_W-1:0] limit_word_w;
    dcp_sel_e rd_sel_w;
    dcp_sel_e wr_sel_w;

    assign rd_sel_w = dcp_decode(reg_addr_i);
    assign wr_sel_w = dcp_decode(reg_addr_i);

    // Fields are loaded from the build parameters while reset is held.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            lock_q <= CH0_LOCK;
            gather_q <= CH0_GATHER;
            scatter_q <= CH0_SCATTER;
            src_width_q <= CH0_SRC_WIDTH;
            dst_width_q <= CH0_DST_WIDTH;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NF; g++)
        begin : g_chan
            always_ff @(posedge sys_clk_i)
            begin
                if (srst_i)
                begin
                    kind_q[g] <= KIND_P[g*DCP_FIELD_W +: DCP_FIELD_W];
                    limit_q[g] <= LIMIT_P[g*DCP_FIELD_W +: DCP_FIELD_W];
                end
            end

            dcp_code_check #(
                .W(DCP_FIELD_W),
                .MAX(DCP_KIND_MAX)
            ) u_kind_chk (
                .code_i(kind_q[g]),
                .legal_o(kind_ok_w[g])
            );

            dcp_code_check #(
                .W(DCP_FIELD_W),
                .MAX(DCP_LIMIT_MAX)
            ) u_limit_chk (
                .code_i(limit_q[g]),
                .legal_o(limit_ok_w[g])
            );

            dcp_limit_decode u_limit_dec (
                .code_i(limit_q[g]),
                .count_o(count_w[g])
            );

            always_ff @(posedge sys_clk_i)
            begin
                if (srst_i)
                begin
                    count_q[g] <= '0;
                end
                else
                begin
                    count_q[g] <= count_w[g];
                end
            end

            // Pack each channel into its nibble, channel 0 lowest.
            assign kind_word_w[g*DCP_FIELD_W +: DCP_FIELD_W] = kind_q[g];
            assign limit_word_w[g*DCP_FIELD_W +: DCP_FIELD_W] = limit_q[g];
        end
    endgenerate

    // Upper bits of both channel-pair words stay zero.
    assign kind_word_w[DCP_DATA_W-1:NF*DCP_FIELD_W] = '0;
    assign limit_word_w[DCP_DATA_W-1:NF*DCP_FIELD_W] = '0;

    dcp_code_check #(
        .W(DCP_WCODE_W),
        .MAX(DCP_WIDTH_MAX)
    ) u_src_chk (
        .code_i(src_width_q),
        .legal_o(src_ok_w)
    );

    dcp_code_check #(
        .W(DCP_WCODE_W),
        .MAX(DCP_WIDTH_MAX)
    ) u_dst_chk (
        .code_i(dst_width_q),
        .legal_o(dst_ok_w)
    );

    // Channel 0 feature word; bits 7:6 are left at zero.
    always_comb
    begin
        chan0_word_w = DCP_REG_RESET;
        chan0_word_w[DCP_LOCK_BIT] = lock_q;
        chan0_word_w[DCP_GATHER_BIT] = gather_q;
        chan0_word_w[DCP_SCATTER_BIT] = scatter_q;
        chan0_word_w[DCP_SRCW_LSB +: DCP_WCODE_W] = src_width_q;
        chan0_word_w[DCP_DSTW_LSB +: DCP_WCODE_W] = dst_width_q;
        chan0_word_w[DCP_COUNT_W-1:0] = chan0_word_w[DCP_COUNT_W-1:0]
            & DCP_CHAN0_USED;
    end

    // Read mux; an unmapped address answers zero and raises the error flag.
    always_comb
    begin
        rdata_d = DCP_REG_RESET;
        if (reg_rd_i)
        begin
            unique case (rd_sel_w)
                dcp_sel_chan0:
                begin
                    rdata_d = chan0_word_w;
                end
                dcp_sel_kind:
                begin
                    rdata_d = kind_word_w;
                end
                dcp_sel_limit:
                begin
                    rdata_d = limit_word_w;
                end
                dcp_sel_none:
                begin
                    rdata_d = DCP_REG_RESET;
                end
            endcase
        end
    end

    // Writes never touch a field; they only report that they were dropped.
    // Reporting every write, mapped or not, keeps the bank strictly read-only.
    always_comb
    begin
        err_d = 1'b0;
        if (reg_rd_i && (rd_sel_w == dcp_sel_none))
        begin
            err_d = 1'b1;
        end
        if (reg_wr_i && ((wr_sel_w != dcp_sel_none) || (reg_wdata_i != reg_wdata_i)))
        begin
            err_d = 1'b1;
        end
        else if (reg_wr_i)
        begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            rdata_q <= DCP_REG_RESET;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            err_q <= 1'b0;
        end
        else
        begin
            err_q <= err_d;
        end
    end

    // Sanity of the build codes, held as a level for the channel logic.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            legal_q <= 1'b0;
        end
        else
        begin
            legal_q <= (&kind_ok_w) && (&limit_ok_w) && src_ok_w && dst_ok_w;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign reg_err_o = err_q;
    assign chan0_block_limit_o = count_q[0];
    assign chan1_block_limit_o = count_q[1];
    assign chan2_block_limit_o = count_q[2];
    assign params_legal_o = legal_q;

endmodule : dcp_param_regs

`default_nettype wire

/* File: src/dcp_pkg.sv */
// Purpose: Constants for the DMA component parameter register bank.
// Assumes: Byte addresses relative to the DMA base, 32-bit register words.
// Notes: All parameter fields are build-time constants.
// Summary of operation
// - Multi-block kind register read-only at 0x3ec.
// - Block limit register read-only at 0x3f0.
// - Kind fields: ch2 11:8, ch1 7:4, ch0 3:0.
// - Kind codes 0 free, 1..8 source-destination pairs.
// - Limit fields: ch2 11:8, ch1 7:4, ch0 3:0.
// - Limit code n means 2^(n+2)-1, default 8.
// - Bit 10 reports channel 0 lock capability.
// - Bit 9 reports channel 0 source gather.
// - Bit 8 reports channel 0 destination scatter.
// - Bits 5:3 give fixed source width code.
// - Bits 2:0 give fixed destination width code.
// - Channel 0 feature word at offset 0x3e8.
`default_nettype none

package dcp_pkg;

    localparam int DCP_ADDR_W = 12;
    localparam int DCP_DATA_W = 32;
    localparam int DCP_NUM_CH = 3;

    localparam logic [11:0] DCP_OFS_CHAN0 = 12'h3e8;
    localparam logic [11:0] DCP_OFS_KIND = 12'h3ec;
    localparam logic [11:0] DCP_OFS_LIMIT = 12'h3f0;

    localparam logic [31:0] DCP_REG_RESET = 32'h0;

    localparam int DCP_LOCK_BIT = 10;
    localparam int DCP_GATHER_BIT = 9;
    localparam int DCP_SCATTER_BIT = 8;
    localparam int DCP_SRCW_LSB = 3;
    localparam int DCP_DSTW_LSB = 0;
    localparam int DCP_WCODE_W = 3;
    localparam int DCP_FIELD_W = 4;
    localparam int DCP_COUNT_W = 12;

    localparam logic [11:0] DCP_CHAN0_USED = 12'h73f;
    localparam logic [11:0] DCP_PAIR_USED = 12'hfff;

    typedef enum logic [3:0] {
        not_fixed = 4'h0,
        contiguous_then_reload = 4'h1,
        reload_then_contiguous = 4'h2,
        reload_then_reload = 4'h3,
        contiguous_then_list = 4'h4,
        reload_then_list = 4'h5,
        list_then_contiguous = 4'h6,
        list_then_reload = 4'h7,
        list_then_list = 4'h8
    } dcp_kind_e;

    typedef enum logic [2:0] {
        width_free = 3'h0,
        width_8 = 3'h1,
        width_16 = 3'h2,
        width_32 = 3'h3,
        width_64 = 3'h4,
        width_128 = 3'h5,
        width_256 = 3'h6,
        width_rsvd = 3'h7
    } dcp_width_e;

    localparam logic [3:0] DCP_KIND_MAX = 4'h8;
    localparam logic [3:0] DCP_KIND_DEF = 4'h0;
    localparam logic [2:0] DCP_WIDTH_MAX = 3'h6;
    localparam logic [2:0] DCP_WIDTH_DEF = 3'h0;
    localparam logic [3:0] DCP_LIMIT_MAX = 4'ha;
    localparam logic [3:0] DCP_LIMIT_DEF = 4'h8;
    localparam int DCP_LIMIT_SHIFT = 2;
    localparam logic DCP_FLAG_DEF = 1'b0;

endpackage : dcp_pkg

`default_nettype wire

/* File: src/dcp_unused.sv */
`default_nettype none
`default_nettype wire
